// ---- conv_regs_pkg.sv ----
package conv_regs_pkg;
   // ----------------------------------------------------------------
   // Serial port framing
   // ----------------------------------------------------------------
   localparam int ADDR_W      = 13;
   localparam int INSTR_BITS  = 16;
   localparam int RNW_BIT     = 15;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [12:0] OFS_TEST2_LOW   = 13'h001B;
   localparam logic [12:0] OFS_TEST2_HIGH  = 13'h001C;
   localparam logic [12:0] OFS_SIGNATURE   = 13'h0024;
   localparam logic [12:0] OFS_OVER_RANGE  = 13'h002A;
   localparam logic [12:0] OFS_CHAN_SOURCE = 13'h002E;
   localparam logic [12:0] OFS_SYNC_CTL    = 13'h0100;
   localparam logic [12:0] OFS_MISC_USER   = 13'h0101;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_TEST2      = 8'h00;
   localparam logic [7:0] RST_OVER_RANGE = 8'h01;
   localparam logic [1:0] RST_CHAN_SRC   = 2'h2;
   localparam logic [2:0] RST_SYNC_CTL   = 3'h1;
   localparam logic [7:0] RST_MISC_USER  = 8'h88;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int SYNC_MASTER_BIT = 0;
   localparam int SYNC_DIV_BIT    = 1;
   localparam int SYNC_NEXT_BIT   = 2;
   localparam int USR_PD_DIS_BIT  = 0;
   localparam int USR_RUN_OSC_BIT = 2;
   localparam int USR_DETECT_BIT  = 3;
   localparam int USR_OE_PIN_BIT  = 7;
   localparam logic [7:0] MISC_USER_MASK = 8'h8D;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ         = 125;
   localparam int LOW_RATE_MSPS   = 5;
   // Longest encode period that still counts as a normal rate
   localparam int LOW_RATE_CYCLES = CLK_MHZ / LOW_RATE_MSPS;
endpackage

// ---- reg_port_if.sv ----
`timescale 1ns/1ns
// Write strobe and read path between the serial slave and register bank
interface reg_port_if;
   logic        wr_stb;
   logic [12:0] addr;
   logic [7:0]  wdata;
   logic [7:0]  rdata;
   modport port (output wr_stb, output addr, output wdata, input rdata);
   modport bank (input wr_stb, input addr, input wdata, output rdata);
endinterface

// ---- serial_reg_port.sv ----
`timescale 1ns/1ns
module serial_reg_port (
   input  wire logic   clk,
   input  wire logic   srst,
   input  wire logic   sclk_pin,
   input  wire logic   csb_pin,
   input  wire logic   sdio_in,
   output logic        sdio_out,
   output logic        sdio_oe,
   reg_port_if.port    bus
);
   logic [2:0]  sclk_q;
   logic [1:0]  csb_q;
   logic [1:0]  sdio_q;
   logic [3:0]  bit_cnt_q;
   logic [15:0] instr_q;
   logic [7:0]  in_sh_q;
   logic [7:0]  out_sh_q;
   logic        data_ph_q;
   logic        rnw_q;
   logic        load_q;
   logic        wr_q;
   logic [12:0] addr_q;
   logic [7:0]  wdata_q;
   logic        rise;
   logic        fall;

   // Pins are asynchronous to the sample clock: two flops before use
   always_ff @(posedge clk) begin
      if (srst) begin
         sclk_q <= 3'h0;
         csb_q  <= 2'h3;
         sdio_q <= 2'h0;
      end else begin
         sclk_q <= {sclk_q[1:0], sclk_pin};
         csb_q  <= {csb_q[0], csb_pin};
         sdio_q <= {sdio_q[0], sdio_in};
      end
   end

   assign rise = sclk_q[1] & ~sclk_q[2] & ~csb_q[1];
   assign fall = ~sclk_q[1] & sclk_q[2] & ~csb_q[1];

   // Instruction then data bytes, MSB first; address steps up per byte
   always_ff @(posedge clk) begin
      if (srst || csb_q[1]) begin
         bit_cnt_q <= 4'h0;
         data_ph_q <= 1'b0;
         rnw_q     <= 1'b0;
         load_q    <= 1'b0;
         wr_q      <= 1'b0;
         instr_q   <= 16'h0000;
         in_sh_q   <= 8'h00;
         addr_q    <= 13'h0000;
         wdata_q   <= 8'h00;
      end else begin
         load_q <= 1'b0;
         wr_q   <= 1'b0;
         if (wr_q) begin
            addr_q <= addr_q + 13'h0001;
         end
         if (rise && !data_ph_q) begin
            instr_q   <= {instr_q[14:0], sdio_q[1]};
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == 4'hF) begin
               addr_q    <= {instr_q[11:0], sdio_q[1]};
               rnw_q     <= instr_q[conv_regs_pkg::RNW_BIT - 1];
               data_ph_q <= 1'b1;
               load_q    <= 1'b1;
               bit_cnt_q <= 4'h0;
            end
         end else if (rise) begin
            in_sh_q   <= {in_sh_q[6:0], sdio_q[1]};
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == 4'h7) begin
               bit_cnt_q <= 4'h0;
               if (rnw_q) begin
                  addr_q <= addr_q + 13'h0001;
                  load_q <= 1'b1;
               end else begin
                  wr_q    <= 1'b1;
                  wdata_q <= {in_sh_q[6:0], sdio_q[1]};
               end
            end
         end
      end
   end

   // Read data leaves on falling edges so the host samples it on rising
   always_ff @(posedge clk) begin
      if (srst || csb_q[1]) begin
         out_sh_q <= 8'h00;
         sdio_out <= 1'b0;
         sdio_oe  <= 1'b0;
      end else begin
         sdio_oe <= data_ph_q & rnw_q;
         if (load_q) begin
            out_sh_q <= bus.rdata;
         end else if (fall && data_ph_q && rnw_q) begin
            sdio_out <= out_sh_q[7];
            out_sh_q <= {out_sh_q[6:0], 1'b0};
         end
      end
   end

   assign bus.wr_stb = wr_q;
   assign bus.addr   = addr_q;
   assign bus.wdata  = wdata_q;
endmodule // serial_reg_port

// ---- conv_feature_regs.sv ----
// What this block does
// - Master sync enable gates every sync function
// - Divider sync bit gates pulse to divider
// - Continuous mode realigns on every sync pulse
// - Next-sync-only aligns once, ignores later pulses
// - Hardware clears divider sync bit after sync in next-sync-only mode
// - Output-enable control bit makes pin active
// - Control bit cleared means pin ignored
// - Detector flags encode rates below 5 MSPS
// - Low rate switches internal oscillator on
// - Detect bit cleared disables the detector
// - Force bit runs oscillator regardless of detector
// - Pull-down disable bit removes serial pull-down
`timescale 1ns/1ns
module conv_feature_regs #(
   parameter int NUM_CH = 2
) (
   input  wire logic              CLK,
   input  wire logic              SRST,
   input  wire logic              SCLK,
   input  wire logic              CSB,
   input  wire logic              SDIO_IN,
   output logic                   SDIO_OUT,
   output logic                   SDIO_OE,
   input  wire logic              SYNC_PIN,
   input  wire logic              ENCODE_PIN,
   input  wire logic              OUTPUT_ENABLE_PIN_ACTIVE_LOW,
   input  wire logic [NUM_CH-1:0] CHANNEL_INDEX,
   input  wire logic [NUM_CH-1:0] OVER_RANGE_IN,
   input  wire logic [7:0]        SIGNATURE_ACCUMULATOR,
   output logic                   DIV_ALIGN,
   output logic                   DATA_OUT_EN,
   output logic                   ENCODE_RATE_LOW,
   output logic                   LOW_RATE_INTERNAL_OSCILLATOR_RUN,
   output logic                   SDIO_PULLDOWN_EN,
   output logic [NUM_CH-1:0]      OVER_RANGE_OUT,
   output logic [NUM_CH-1:0]      CHAN_SOURCE_B,
   output logic [15:0]            TEST_WORD2
);
   localparam logic [7:0] RATE_TH = 8'(conv_regs_pkg::LOW_RATE_CYCLES);

   reg_port_if bus ();

   logic [2:0]        sync_q;
   logic [2:0]        enc_q;
   logic [1:0]        oe_pin_q;
   logic [2:0]        sync_ctl_q;
   logic [7:0]        usr_q;
   logic [7:0]        sig_q;
   logic [7:0]        gap_q;
   logic [NUM_CH-1:0] or_en_q;
   logic [NUM_CH-1:0] src_q;
   logic              sync_rise;
   logic              sync_gated;
   logic              enc_rise;
   logic              wr_sync;
   logic              wr_usr;

   // ----------------------------------------------------------------
   // Serial port
   // ----------------------------------------------------------------
   serial_reg_port u_port (
      .clk      (CLK),
      .srst     (SRST),
      .sclk_pin (SCLK),
      .csb_pin  (CSB),
      .sdio_in  (SDIO_IN),
      .sdio_out (SDIO_OUT),
      .sdio_oe  (SDIO_OE),
      .bus      (bus.port)
   );

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Third stage of sync and encode only feeds the edge detectors
   always_ff @(posedge CLK) begin
      if (SRST) begin
         sync_q   <= 3'h0;
         enc_q    <= 3'h0;
         oe_pin_q <= 2'h3;
      end else begin
         sync_q   <= {sync_q[1:0], SYNC_PIN};
         enc_q    <= {enc_q[1:0], ENCODE_PIN};
         oe_pin_q <= {oe_pin_q[0], OUTPUT_ENABLE_PIN_ACTIVE_LOW};
      end
   end

   assign sync_rise = sync_q[1] & ~sync_q[2];
   assign enc_rise  = enc_q[1] & ~enc_q[2];
   assign wr_sync   = bus.wr_stb && bus.addr == conv_regs_pkg::OFS_SYNC_CTL;
   assign wr_usr    = bus.wr_stb && bus.addr == conv_regs_pkg::OFS_MISC_USER;
   assign sync_gated = sync_rise
      & sync_ctl_q[conv_regs_pkg::SYNC_MASTER_BIT]
      & sync_ctl_q[conv_regs_pkg::SYNC_DIV_BIT];

   // ----------------------------------------------------------------
   // Global registers
   // ----------------------------------------------------------------
   // A host write wins over the one-shot self clear in the same cycle
   always_ff @(posedge CLK) begin
      if (SRST) begin
         sync_ctl_q <= conv_regs_pkg::RST_SYNC_CTL;
      end else if (wr_sync) begin
         sync_ctl_q <= bus.wdata[2:0];
      end else if (sync_gated && sync_ctl_q[conv_regs_pkg::SYNC_NEXT_BIT]) begin
         sync_ctl_q[conv_regs_pkg::SYNC_DIV_BIT] <= 1'b0;
      end
   end

   // Only documented bits store; open bits read back as zero
   always_ff @(posedge CLK) begin
      if (SRST) begin
         usr_q <= conv_regs_pkg::RST_MISC_USER;
      end else if (wr_usr) begin
         usr_q <= bus.wdata & conv_regs_pkg::MISC_USER_MASK;
      end
   end

   // Test word, signature capture
   always_ff @(posedge CLK) begin
      if (SRST) begin
         TEST_WORD2 <= {conv_regs_pkg::RST_TEST2, conv_regs_pkg::RST_TEST2};
         sig_q      <= 8'h00;
      end else begin
         sig_q <= SIGNATURE_ACCUMULATOR;
         if (bus.wr_stb && bus.addr == conv_regs_pkg::OFS_TEST2_LOW) begin
            TEST_WORD2[7:0] <= bus.wdata;
         end
         if (bus.wr_stb && bus.addr == conv_regs_pkg::OFS_TEST2_HIGH) begin
            TEST_WORD2[15:8] <= bus.wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // Per-channel registers
   // ----------------------------------------------------------------
   // A write lands in every channel selected by the index mask
   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      always_ff @(posedge CLK) begin
         if (SRST) begin
            or_en_q[ch] <= conv_regs_pkg::RST_OVER_RANGE[0];
            src_q[ch]   <= conv_regs_pkg::RST_CHAN_SRC[ch];
         end else if (bus.wr_stb && CHANNEL_INDEX[ch]) begin
            if (bus.addr == conv_regs_pkg::OFS_OVER_RANGE) begin
               or_en_q[ch] <= bus.wdata[0];
            end
            if (bus.addr == conv_regs_pkg::OFS_CHAN_SOURCE) begin
               src_q[ch] <= bus.wdata[0];
            end
         end
      end
      // Pin is forced low while its enable is clear
      always_ff @(posedge CLK) begin
         if (SRST) begin
            OVER_RANGE_OUT[ch] <= 1'b0;
            CHAN_SOURCE_B[ch]  <= 1'b0;
         end else begin
            OVER_RANGE_OUT[ch] <= OVER_RANGE_IN[ch] & or_en_q[ch];
            CHAN_SOURCE_B[ch]  <= src_q[ch];
         end
      end
   end

   // ----------------------------------------------------------------
   // Read decode
   // ----------------------------------------------------------------
   // Local reads show the lowest-numbered selected channel
   always_comb begin
      bus.rdata = 8'h00;
      unique case (bus.addr)
         conv_regs_pkg::OFS_TEST2_LOW:   bus.rdata = TEST_WORD2[7:0];
         conv_regs_pkg::OFS_TEST2_HIGH:  bus.rdata = TEST_WORD2[15:8];
         conv_regs_pkg::OFS_SIGNATURE:   bus.rdata = sig_q;
         conv_regs_pkg::OFS_OVER_RANGE:
            bus.rdata = {7'h00, CHANNEL_INDEX[0] ? or_en_q[0] : or_en_q[1]};
         conv_regs_pkg::OFS_CHAN_SOURCE:
            bus.rdata = {7'h00, CHANNEL_INDEX[0] ? src_q[0] : src_q[1]};
         conv_regs_pkg::OFS_SYNC_CTL:    bus.rdata = {5'h00, sync_ctl_q};
         conv_regs_pkg::OFS_MISC_USER:   bus.rdata = usr_q;
         default:                        bus.rdata = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // Divider alignment and pin controls
   // ----------------------------------------------------------------
   // Continuous mode keeps the divider bit, so every pulse realigns
   always_ff @(posedge CLK) begin
      if (SRST) begin
         DIV_ALIGN        <= 1'b0;
         DATA_OUT_EN      <= 1'b1;
         SDIO_PULLDOWN_EN <= 1'b1;
      end else begin
         DIV_ALIGN        <= sync_gated;
         DATA_OUT_EN      <= usr_q[conv_regs_pkg::USR_OE_PIN_BIT]
                             ? ~oe_pin_q[1] : 1'b1;
         SDIO_PULLDOWN_EN <= ~usr_q[conv_regs_pkg::USR_PD_DIS_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Low encode rate detector and oscillator
   // ----------------------------------------------------------------
   // A stopped encode clock also reads as low once the gap saturates
   always_ff @(posedge CLK) begin
      if (SRST || !usr_q[conv_regs_pkg::USR_DETECT_BIT]) begin
         gap_q           <= 8'h00;
         ENCODE_RATE_LOW <= 1'b0;
      end else if (enc_rise) begin
         gap_q           <= 8'h00;
         ENCODE_RATE_LOW <= gap_q >= RATE_TH;
      end else begin
         if (gap_q < RATE_TH) begin
            gap_q <= gap_q + 8'h01;
         end
         ENCODE_RATE_LOW <= ENCODE_RATE_LOW | (gap_q >= RATE_TH);
      end
   end

   // Force bit overrides; detector only counts while enabled
   always_ff @(posedge CLK) begin
      if (SRST) begin
         LOW_RATE_INTERNAL_OSCILLATOR_RUN <= 1'b0;
      end else begin
         LOW_RATE_INTERNAL_OSCILLATOR_RUN <=
            usr_q[conv_regs_pkg::USR_RUN_OSC_BIT] |
            (usr_q[conv_regs_pkg::USR_DETECT_BIT] & ENCODE_RATE_LOW);
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   master_gate_a: assert property (@(posedge CLK) disable iff (SRST)
      sync_rise && !sync_ctl_q[0] |=> !DIV_ALIGN)
      else $error("sync passed with master enable low");
   div_gate_a: assert property (@(posedge CLK) disable iff (SRST)
      DIV_ALIGN |-> $past(sync_rise) && $past(sync_ctl_q[1]))
      else $error("divider aligned without its enable");
   continuous_sync_a: assert property (@(posedge CLK) disable iff (SRST)
      sync_rise && sync_ctl_q == 3'h3 && !wr_sync
      |=> DIV_ALIGN && sync_ctl_q[1])
      else $error("continuous sync missed a pulse");
   next_only_a: assert property (@(posedge CLK) disable iff (SRST)
      sync_rise && sync_ctl_q == 3'h7 && !wr_sync
      |=> DIV_ALIGN ##1 !DIV_ALIGN [*2])
      else $error("next sync only realigned twice");
   self_clear_a: assert property (@(posedge CLK) disable iff (SRST)
      sync_gated && sync_ctl_q[2] && !wr_sync |=> !sync_ctl_q[1])
      else $error("divider sync bit not cleared");
   oe_pin_a: assert property (@(posedge CLK) disable iff (SRST)
      !SRST && usr_q[7] |=> DATA_OUT_EN == !$past(oe_pin_q[1]))
      else $error("output enable does not follow pin");
   oe_ignore_a: assert property (@(posedge CLK) disable iff (SRST)
      !usr_q[7] |=> DATA_OUT_EN)
      else $error("pin used while disabled");
   rate_low_a: assert property (@(posedge CLK) disable iff (SRST)
      usr_q[3] && !wr_usr && gap_q == RATE_TH |=> ENCODE_RATE_LOW)
      else $error("low encode rate not flagged");
   osc_off_a: assert property (@(posedge CLK) disable iff (SRST)
      !usr_q[3] && !usr_q[2] |=> !LOW_RATE_INTERNAL_OSCILLATOR_RUN)
      else $error("oscillator on with detector off");
   osc_force_a: assert property (@(posedge CLK) disable iff (SRST)
      usr_q[2] |=> LOW_RATE_INTERNAL_OSCILLATOR_RUN)
      else $error("forced oscillator not running");
   pulldown_a: assert property (@(posedge CLK) disable iff (SRST)
      ##1 SDIO_PULLDOWN_EN == !$past(usr_q[0]))
      else $error("pull-down control wrong");
   over_range_a: assert property (@(posedge CLK) disable iff (SRST)
      OVER_RANGE_OUT[0] |-> $past(or_en_q[0]) && $past(OVER_RANGE_IN[0]))
      else $error("over-range pin active while disabled");
endmodule // conv_feature_regs

// ---- serial_host_model.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Serial host driving the three-wire register port
// ----------------------------------------------------------------
module serial_host_model (
   input  wire logic CLK,
   input  wire logic SDIO_OUT,
   output logic      SCLK,
   output logic      CSB,
   output logic      SDIO_HOST,
   output logic      HOST_DRV
);
   // Idle: chip select high, serial clock parked low between frames
   initial begin
      SCLK = 1'b0;
      CSB = 1'b1;
      SDIO_HOST = 1'b0;
      HOST_DRV = 1'b1;
   end

   // One frame; half sets the speed, read data is taken late in the
   // low phase since the device answers a few cycles after a fall
   task automatic frame(input logic rnw, input logic [12:0] addr,
                        input int nbytes, input int half,
                        input logic [15:0] wdat, output logic [15:0] rdat);
      logic [31:0] sh;
      sh = {rnw, 2'b00, addr, wdat};
      rdat = 16'h0000;
      @(posedge CLK);
      CSB <= 1'b0;
      for (int i = 0; i < 16 + 8 * nbytes; i++) begin
         SCLK <= 1'b0;
         HOST_DRV <= !(rnw && i >= 16);
         SDIO_HOST <= sh[31 - i];
         repeat (half) @(posedge CLK);
         if (rnw && i >= 16)
            rdat = {rdat[14:0], SDIO_OUT};
         SCLK <= 1'b1;
         repeat (half) @(posedge CLK);
      end
      SCLK <= 1'b0;
      HOST_DRV <= 1'b1;
      repeat (half) @(posedge CLK);
      CSB <= 1'b1;
      repeat (half) @(posedge CLK);
   endtask
endmodule // serial_host_model

// ---- test_conv_feature_regs.sv ----
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
   $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module test_conv_feature_regs;
   logic        clk = 0, srst = 1, sync_pin = 0, encode_pin = 0;
   logic        oe_pin_n = 1, enc_run = 1;
   logic [1:0]  chan_idx = 2'h1, or_in = 2'h0;
   logic [7:0]  sig = 8'h00;
   logic        sdio_out, sdio_oe, div_align, data_out_en, rate_low;
   logic        osc_run, pd_en, sclk, csb, host_sdio, host_drv;
   logic [1:0]  or_out, src_b;
   logic [15:0] test_word, rd, wv;
   wire         sdio_w;
   // Behavioural register model
   logic [7:0]  sync_m = 8'h01, misc_m = 8'h88, tw_lo = 8'h00;
   logic [7:0]  tw_hi = 8'h00;
   logic [1:0]  orr_m = 2'h3, src_m = 2'h2;
   int          fails = 0, checked = 0, cycles = 0, aligns = 0;
   int          exp_al = 0, enc_div = 0;
   logic [12:0] addrs [8] = '{13'h1B, 13'h1C, 13'h24, 13'h2A, 13'h2E,
                              13'h100, 13'h101, 13'h30};
   logic [7:0]  miscs [6] = '{8'h80, 8'h00, 8'h01, 8'h04, 8'h08, 8'h88};
   logic [7:0]  syncs [4] = '{8'h01, 8'h02, 8'h03, 8'h07};

   // Released data line: pull-down level, else the inverse of last value
   assign sdio_w = sdio_oe ? sdio_out : host_drv ? host_sdio :
                   pd_en ? 1'b0 : ~host_sdio;

   conv_feature_regs conv_feature_regs_i (
      .CLK(clk), .SRST(srst), .SCLK(sclk), .CSB(csb), .SDIO_IN(sdio_w),
      .SDIO_OUT(sdio_out), .SDIO_OE(sdio_oe), .SYNC_PIN(sync_pin),
      .ENCODE_PIN(encode_pin), .OUTPUT_ENABLE_PIN_ACTIVE_LOW(oe_pin_n),
      .CHANNEL_INDEX(chan_idx), .OVER_RANGE_IN(or_in),
      .SIGNATURE_ACCUMULATOR(sig), .DIV_ALIGN(div_align),
      .DATA_OUT_EN(data_out_en), .ENCODE_RATE_LOW(rate_low),
      .LOW_RATE_INTERNAL_OSCILLATOR_RUN(osc_run),
      .SDIO_PULLDOWN_EN(pd_en), .OVER_RANGE_OUT(or_out),
      .CHAN_SOURCE_B(src_b), .TEST_WORD2(test_word));
   serial_host_model serial_host_model_i (
      .CLK(clk), .SDIO_OUT(sdio_w), .SCLK(sclk), .CSB(csb),
      .SDIO_HOST(host_sdio), .HOST_DRV(host_drv));

   initial begin
      forever #4 clk = ~clk;
   end

   // Encode clock at 10 cycles a period, well above the low threshold
   always @(posedge clk) begin
      cycles++;
      // Unknown counts as a pulse so it cannot hide behind a zero count
      if (div_align !== 1'b0 && !srst)
         aligns++;
      if (enc_run && ++enc_div >= 5) begin
         encode_pin <= ~encode_pin;
         enc_div = 0;
      end
      if (cycles == 60000) begin
         fails++;
         test_done;
      end
   end

   // ----------------------------------------------------------------
   // Model and helpers
   // ----------------------------------------------------------------
   function automatic void mwr(logic [12:0] a, logic [7:0] d);
      case (a)
         13'h01B: tw_lo = d;
         13'h01C: tw_hi = d;
         13'h02A: orr_m = (orr_m & ~chan_idx) | ({2{d[0]}} & chan_idx);
         13'h02E: src_m = (src_m & ~chan_idx) | ({2{d[0]}} & chan_idx);
         13'h100: sync_m = d & 8'h07;
         13'h101: misc_m = d & conv_regs_pkg::MISC_USER_MASK;
         default: ;
      endcase
   endfunction

   function automatic logic [7:0] mrd(logic [12:0] a);
      case (a)
         13'h01B: return tw_lo;
         13'h01C: return tw_hi;
         13'h024: return sig;
         13'h02A: return {7'h00, chan_idx[0] ? orr_m[0] : orr_m[1]};
         13'h02E: return {7'h00, chan_idx[0] ? src_m[0] : src_m[1]};
         13'h100: return sync_m;
         13'h101: return misc_m;
         default: return 8'h00;
      endcase
   endfunction

   task automatic wr(logic [12:0] a, logic [7:0] d);
      serial_host_model_i.frame(1'b0, a, 1, 6, {d, 8'h00}, rd);
      mwr(a, d);
      repeat (10) @(posedge clk);
   endtask

   task automatic rd_chk(logic [12:0] a);
      serial_host_model_i.frame(1'b1, a, 1, 9, 16'h0000, rd);
      `CHK(rd[7:0], mrd(a))
   endtask

   task automatic chk_outs;
      logic low;
      low = misc_m[3] & ~enc_run;
      `CHK(data_out_en, misc_m[7] ? ~oe_pin_n : 1'b1)
      `CHK(pd_en, ~misc_m[0])
      `CHK(rate_low, low)
      `CHK(osc_run, misc_m[2] | low)
      `CHK(or_out, orr_m & or_in)
      `CHK(src_b, src_m)
      `CHK(test_word, {tw_hi, tw_lo})
   endtask

   // Sync pulse; model realigns only with both enables, once if next-only
   task automatic pulse;
      if (sync_m[0] & sync_m[1]) begin
         exp_al++;
         if (sync_m[2])
            sync_m[1] = 1'b0;
      end
      sync_pin <= 1'b1;
      repeat (4) @(posedge clk);
      sync_pin <= 1'b0;
      repeat (12) @(posedge clk);
   endtask

   task automatic test_done;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(3));
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      sig <= 8'($urandom);
      repeat (5) @(posedge clk);
      chk_outs;
      foreach (addrs[i]) rd_chk(addrs[i]);
      // Streaming write: second byte lands one address higher
      wv = 16'($urandom);
      serial_host_model_i.frame(1'b0, 13'h1B, 2, 6, wv, rd);
      mwr(13'h1B, wv[15:8]);
      mwr(13'h1C, wv[7:0]);
      repeat (10) @(posedge clk);
      chk_outs;
      // Streaming read walks the same two places upward
      serial_host_model_i.frame(1'b1, 13'h1B, 2, 9, 16'h0000, rd);
      `CHK(rd, {tw_lo, tw_hi})
      // Read-only and unmapped places ignore writes
      wr(13'h24, 8'hFF);
      wr(13'h30, 8'hFF);
      foreach (addrs[i]) rd_chk(addrs[i]);
      for (int i = 0; i < 4; i++) begin
         oe_pin_n <= 1'($urandom);
         wr(13'h101, 8'($urandom));
         chk_outs;
      end
      // Each user setting checked with the encode clock running, then stopped
      foreach (miscs[i]) begin
         oe_pin_n <= 1'b1;
         wr(13'h101, miscs[i]);
         for (int r = 1; r >= 0; r--) begin
            enc_run <= 1'(r);
            repeat (60) @(posedge clk);
            chk_outs;
         end
         rd_chk(13'h101);
      end
      chan_idx <= 2'h1;
      or_in <= 2'h3;
      wr(13'h2A, 8'h00);
      chk_outs;
      rd_chk(13'h2A);
      chan_idx <= 2'h3;
      wr(13'h2E, 8'h01);
      chk_outs;
      wr(13'h2A, 8'h01);
      wr(13'h2E, 8'h02);
      chk_outs;
      foreach (syncs[i]) begin
         wr(13'h100, syncs[i]);
         pulse;
         pulse;
         `CHK(aligns, exp_al)
         rd_chk(13'h100);
      end
      test_done;
   end
endmodule // test_conv_feature_regs
